//--- logic/dlf_pkg.sv
/*
 * shared constants and types of the line delay buffer.
 * assumes a single system clock; the port clocks are sampled pins.
 */
package dlf_pkg;

   // ************************************************************
   // geometry
   // ************************************************************
   localparam int DLF_DATA_W = 8;
   localparam int DLF_ADDR_W = 13;
   localparam int DLF_LINE_WORDS = 5120;
   localparam logic [DLF_ADDR_W-1:0] DLF_LAST_ADDR = 13'h13FF;
   localparam logic [DLF_ADDR_W-1:0] DLF_ADDR_STEP = 13'h0001;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [DLF_ADDR_W-1:0] DLF_PTR_RESET = 13'h0000;
   localparam logic [DLF_DATA_W-1:0] DLF_WORD_RESET = 8'h00;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic [DLF_ADDR_W-1:0] addr;
      logic [DLF_DATA_W-1:0] data;
   } dlf_wstage_t;

   typedef struct packed {
      logic [DLF_ADDR_W-1:0] wptr;
      logic [DLF_ADDR_W-1:0] rptr;
      dlf_wstage_t cap;
      dlf_wstage_t pend;
      logic [DLF_DATA_W-1:0] q;
   } dlf_state_t;

   typedef struct packed {
      logic level;
   } dlf_edge_state_t;

   localparam dlf_wstage_t DLF_WSTAGE_RESET = '{
      valid: 1'b0, addr: DLF_PTR_RESET, data: DLF_WORD_RESET};

endpackage : dlf_pkg

//--- logic/dlf_edge.sv
/*
 * rising and falling edge detector for a port clock pin.
 * assumes the pin is synchronous to clock_i and at most half its rate.
 */
`timescale 1ns/100ps
module dlf_edge
   import dlf_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);

   // ************************************************************
   // state
   // ************************************************************
   dlf_edge_state_t state_r;
   dlf_edge_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.level = pin_i;
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= '{level: 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // edges
   // ************************************************************
   assign rise_o = pin_i & ~state_r.level;
   assign fall_o = ~pin_i & state_r.level;

endmodule : dlf_edge

//--- logic/dlf_top.sv
/*
 * 5120 x 8 line memory with separate write and read ports, used as a
 * one-line or variable-length delay.
 * assumes write_clock_i and read_clock_i are synchronous to clock_i and
 * run at no more than half its rate; the reader honours the write
 * pipeline latency.
 */
// How it works
// - write enable low stores word, advances pointer
// - write enable high: no store, pointer holds
// - read enable low reads and advances; high floats
// - each pointer reset low clears its pointer
// - cycle n word captured on its own rise
// - memory written in low phase of n+1
// - pointers wrap over 5120 words: one-line delay
// - reading before write n+1 ends is invalid
// - old word readable until next line overwrites
`timescale 1ns/100ps
module dlf_top
   import dlf_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic write_clock_i,
   input wire logic write_enable_n_i,
   input wire logic write_pointer_reset_n_i,
   input wire logic [DLF_DATA_W-1:0] input_word_i,
   input wire logic read_clock_i,
   input wire logic read_enable_n_i,
   input wire logic read_pointer_reset_n_i,
   output logic [DLF_DATA_W-1:0] output_word_o,
   output logic output_word_oe_o,
   output logic write_pending_o
);

   // ************************************************************
   // port clock edges
   // ************************************************************
   logic wclk_rise;
   logic wclk_fall;
   logic rclk_rise;

   dlf_edge u_wclk_edge (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .pin_i(write_clock_i),
      .rise_o(wclk_rise),
      .fall_o(wclk_fall)
   );

   dlf_edge u_rclk_edge (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .pin_i(read_clock_i),
      .rise_o(rclk_rise),
      .fall_o()
   );

   // ************************************************************
   // line memory
   // ************************************************************
   logic [DLF_DATA_W-1:0] line_mem [DLF_LINE_WORDS];

   // ************************************************************
   // state
   // ************************************************************
   dlf_state_t state_r;
   dlf_state_t state_nxt;
   logic commit_now;

   // pointer step with wrap over the whole line
   function automatic logic [DLF_ADDR_W-1:0] dlf_next_addr(
      input logic [DLF_ADDR_W-1:0] a
   );
      logic [DLF_ADDR_W-1:0] n;
      n = DLF_PTR_RESET;
      if (a != DLF_LAST_ADDR) begin
         n = a + DLF_ADDR_STEP;
      end
      return n;
   endfunction : dlf_next_addr

   // ************************************************************
   // port decode
   // ************************************************************
   logic wr_take;
   logic wr_skip;
   logic wr_ptr_clear;
   logic wr_commit_due;
   logic rd_take;
   logic rd_skip;
   logic rd_ptr_clear;
   logic [DLF_ADDR_W-1:0] wptr_step;
   logic [DLF_ADDR_W-1:0] rptr_step;
   logic [DLF_DATA_W-1:0] rd_word;

   // every take, skip and clear strobe is gated by the rise of its own port clock
   assign wr_take = wclk_rise & ~write_enable_n_i;
   assign wr_skip = wclk_rise & write_enable_n_i;
   assign wr_ptr_clear = wclk_rise & ~write_pointer_reset_n_i;
   // the fall after the next rise commits the pending word
   assign wr_commit_due = wclk_fall & state_r.pend.valid;
   assign rd_take = rclk_rise & ~read_enable_n_i;
   assign rd_skip = rclk_rise & read_enable_n_i;
   assign rd_ptr_clear = rclk_rise & ~read_pointer_reset_n_i;
   assign wptr_step = dlf_next_addr(state_r.wptr);
   assign rptr_step = dlf_next_addr(state_r.rptr);
   // committed contents only; a word still in flight is not visible
   assign rd_word = line_mem[state_r.rptr];

   // ************************************************************
   // write side
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      commit_now = 1'b0;

      // falling edge of the cycle after the next rise commits the word
      if (wr_commit_due) begin
         commit_now = 1'b1;
         state_nxt.pend.valid = 1'b0;
      end

      // previous capture moves on at any rise; needs this extra pulse
      if (wclk_rise) begin
         state_nxt.pend = state_r.cap;
         state_nxt.cap.valid = 1'b0;
      end

      // capture word at the current address
      if (wr_take) begin
         state_nxt.cap.valid = 1'b1;
         state_nxt.cap.addr = state_r.wptr;
         state_nxt.cap.data = input_word_i;
         state_nxt.wptr = wptr_step;
      end

      // disabled cycle: pointer stays put
      if (wr_skip) begin
         state_nxt.wptr = state_r.wptr;
      end

      // pointer reset wins over the step
      if (wr_ptr_clear) begin
         state_nxt.wptr = DLF_PTR_RESET;
      end

      // ************************************************************
      // read side
      // ************************************************************
      if (rd_take) begin
         state_nxt.q = rd_word;
         state_nxt.rptr = rptr_step;
      end

      // held read enable lets the read pointer lag
      if (rd_skip) begin
         state_nxt.rptr = state_r.rptr;
      end

      // pointer reset wins over the step
      if (rd_ptr_clear) begin
         state_nxt.rptr = DLF_PTR_RESET;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= '{
            wptr: DLF_PTR_RESET,
            rptr: DLF_PTR_RESET,
            cap: DLF_WSTAGE_RESET,
            pend: DLF_WSTAGE_RESET,
            q: DLF_WORD_RESET};
      end else begin
         state_r <= state_nxt;
      end
   end

   // memory write of the pending word
   always_ff @(posedge clock_i) begin
      if (commit_now) begin
         line_mem[state_r.pend.addr] <= state_r.pend.data;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign output_word_o = state_r.q;
   // outputs float while read enable is high
   assign output_word_oe_o = ~read_enable_n_i;
   assign write_pending_o = state_r.cap.valid | state_r.pend.valid;

endmodule : dlf_top

//--- tb/dlf_sva.sv
/* port assertions of dlf_top.
   assumes port clocks are low while resetn_i is low. */
`timescale 1ns/100ps
module dlf_sva
   import dlf_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic write_clock_i,
   input wire logic write_enable_n_i,
   input wire logic read_clock_i,
   input wire logic read_enable_n_i,
   input wire logic [DLF_DATA_W-1:0] output_word_o,
   input wire logic output_word_oe_o,
   input wire logic write_pending_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   oe_follow_a: assert property (
      output_word_oe_o == !read_enable_n_i) else $error("oe wrong");
   out_cause_a: assert property ($changed(output_word_o) |->
      $past(read_clock_i) && !$past(read_enable_n_i)) else $error("stray read");
   rd_hold_a: assert property (read_enable_n_i &&
      $past(read_enable_n_i) |-> $stable(output_word_o)) else $error("moved");
   pend_set_a: assert property ($rose(write_clock_i) &&
      !write_enable_n_i |=> write_pending_o) else $error("no capture");
   pend_idle_a: assert property (!write_pending_o &&
      !($rose(write_clock_i) && !write_enable_n_i) |=> !write_pending_o)
      else $error("stray capture");
   pend_clr_a: assert property ($fell(write_pending_o) |->
      !$past(write_clock_i) && $past(write_clock_i, 2)) else $error("early");
   pend_hold_a: assert property (write_pending_o &&
      !$fell(write_clock_i) |=> write_pending_o) else $error("lost pending");
   rst_val_a: assert property ($rose(resetn_i) |->
      output_word_o == DLF_WORD_RESET && !write_pending_o) else $error("rst");
   cover property ($rose(write_clock_i) && !write_enable_n_i);
   cover property ($fell(write_pending_o));
   cover property ($changed(output_word_o));
endmodule : dlf_sva
bind dlf_top dlf_sva dlf_sva_inst (.*);

//--- tb/dlf_port_model.sv
/* line logic on both ports; side 0 writes, side 1 reads.
   assumes clock_i is the system clock of dlf_top. */
`timescale 1ns/100ps
module dlf_port_model
   import dlf_pkg::*;
(
   input wire logic clock_i,
   input wire logic [DLF_DATA_W-1:0] output_word_i,
   input wire logic output_word_oe_i,
   output logic [1:0] clk_o,
   output logic [1:0] en_n_o,
   output logic [1:0] rst_n_o,
   output logic [DLF_DATA_W-1:0] input_word_o
);
   initial {clk_o, en_n_o, rst_n_o, input_word_o} = 14'h0F00;
   task automatic pulse(input int s, logic [7:0] d, logic en_n, rst_n,
      output logic [7:0] q);
      @(negedge clock_i);
      input_word_o = d;
      en_n_o[s] = en_n;
      rst_n_o[s] = rst_n;
      clk_o[s] = 1'h1;
      repeat (2) @(negedge clock_i);
      clk_o[s] = 1'h0;
      input_word_o = ~d;
      @(negedge clock_i);
      q = output_word_oe_i ? output_word_i : ~output_word_i;
   endtask : pulse
endmodule : dlf_port_model

//--- tb/dlf_top_tb.sv
/* self-checking bench of dlf_top.
   assumes the port model drives every port pin. */
`timescale 1ns/100ps
module dlf_top_tb
   import dlf_pkg::*;
;
   typedef struct {logic [7:0] d; logic en_n; logic [7:0] q;} dlf_row_t;
   dlf_row_t rows [6] = '{'{8'hA5, 1'h0, 8'hA5}, '{8'h3C, 1'h0, 8'h3C},
      '{8'h77, 1'h1, 8'hC3}, '{8'h81, 1'h0, 8'h81},
      '{8'hFF, 1'h1, 8'h7E}, '{8'h00, 1'h0, 8'h00}};
   logic clock_i = 1'h0;
   logic resetn_i, write_clock_i, write_enable_n_i, write_pointer_reset_n_i;
   logic read_clock_i, read_enable_n_i, read_pointer_reset_n_i;
   logic output_word_oe_o, write_pending_o;
   logic [7:0] input_word_i, output_word_o, q;
   int err_count = 0;
   int comparisons = 0;
   dlf_top dlf_top_inst (.*);
   dlf_port_model dlf_port_model_inst (.clock_i,
      .output_word_i(output_word_o), .output_word_oe_i(output_word_oe_o),
      .clk_o({read_clock_i, write_clock_i}),
      .en_n_o({read_enable_n_i, write_enable_n_i}),
      .rst_n_o({read_pointer_reset_n_i, write_pointer_reset_n_i}),
      .input_word_o(input_word_i));
   initial forever #5 clock_i = ~clock_i;
   task automatic check(input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      err_count += (seen !== exp);
   endtask : check
   task automatic stop_test;
      if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic op(input int s, logic [7:0] d, logic en_n, rst_n);
      dlf_port_model_inst.pulse(s, d, en_n, rst_n, q);
      if (s == 1) check(q, d);
   endtask : op
   initial begin
      resetn_i = 1'h0;
      repeat (16) @(negedge clock_i);
      resetn_i = 1'h1;
      check(output_word_o, DLF_WORD_RESET);
      check({7'h00, write_pending_o}, 8'h00);
      foreach (rows[i]) op(0, rows[i].d, rows[i].en_n, 1'h1);
      op(0, 8'h00, 1'h1, 1'h1);
      foreach (rows[i]) op(1, rows[i].q, rows[i].en_n, 1'h1);
      op(0, 8'hC3, 1'h0, 1'h0);
      op(0, 8'hB1, 1'h0, 1'h1);
      op(1, 8'hC3, 1'h0, 1'h0);
      check({7'h00, write_pending_o}, 8'h01);
      op(1, 8'hA5, 1'h0, 1'h1);
      op(0, 8'h00, 1'h1, 1'h1);
      op(1, 8'h3C, 1'h0, 1'h0);
      op(1, 8'hB1, 1'h0, 1'h1);
      for (int k = 0; k < DLF_LINE_WORDS; k++) op(0, k[7:0], 1'h0, 1'h1);
      check({7'h00, write_pending_o}, 8'h01);
      op(1, 8'h00, 1'h0, 1'h0);
      op(1, 8'hB1, 1'h0, 1'h1);
      op(0, 8'h6D, 1'h0, 1'h1);
      op(0, 8'h00, 1'h1, 1'h1);
      op(1, 8'h6D, 1'h0, 1'h1);
      op(1, 8'h01, 1'h0, 1'h1);
      resetn_i = 1'h0;
      repeat (4) @(negedge clock_i);
      resetn_i = 1'h1;
      check(output_word_o, DLF_WORD_RESET);
      op(1, 8'hFF, 1'h0, 1'h1);
      stop_test();
   end
endmodule : dlf_top_tb
